//--- hw/retimer_channel_lock_adapt_regs.sv
`timescale 1ns/1ns
`include "retimer_lock_map.svh"
module retimer_channel_lock_adapt_regs #(
  parameter int LP_DELAY_CYCLES = `LP_DELAY_MS * `CLK_KHZ,
  parameter int CAP_W = 5
) (
  input wire logic clock_i,                 // register clock
  input wire logic rst_n_i,                 // sync reset, active low
  input wire logic reg_wr_i,                // register write strobe
  input wire logic reg_rd_i,                // register read strobe
  input wire logic [7:0] reg_addr_i,        // register offset
  input wire logic [7:0] reg_wdata_i,       // write data
  output logic [7:0] reg_rdata_o,           // read data, next cycle
  input wire logic [15:0] freq_count_i,     // live frequency error
  input wire logic freq_count_valid_i,      // new count this cycle
  input wire logic signal_detect_i,         // input signal present
  output logic power_down_o,                // low-power shutdown
  input wire logic lock_check_i,            // one lock check now
  input wire logic freq_ok_i,               // ppm criterion met
  input wire logic eye_ok_i,                // eye opening criterion met
  output logic cdr_locked_o,                // lock indication
  input wire logic [3:0] later_step_req_i,  // taps 2-5 step magnitude
  output logic [3:0] later_step_o,          // limited step
  input wire logic [4:0] tap1_weight_req_i, // tap 1 weight magnitude
  output logic [4:0] tap1_weight_o,         // limited weight
  input wire logic [7:0] tol_value_i,       // raw tolerance
  input wire logic tol_enable_i,            // tolerance enable bit
  output logic [9:0] scaled_tol_o,          // scaled tolerance
  output logic tol_active_o,                // tolerance in use
  input wire logic eye_event_i,             // eye threshold event
  output logic eye_irq_o,                   // eye interrupt
  output logic ref_clk_enable_o,            // reference clock on
  output logic fast_lock_o,                 // fast lock mode
  output logic full_search_o,               // full cap-dac search
  input wire logic [CAP_W-1:0] search_start_i,   // search start
  input wire logic [CAP_W-1:0] search_stop_def_i, // default stop
  output logic [CAP_W-1:0] search_stop_o,   // search stop used
  input wire logic eye_scan_override_i,     // eye monitor override
  output logic [1:0] eye_rate_shift_o,      // log2 of rate divisor
  output logic [4:0] eq_start_index_o,      // adaptation start index
  input wire logic [2:0] divider_sel_i,     // divider code
  input wire logic adapt_low_rate_i,        // adapt-at-low-rate enable
  output logic use_fixed_boost_o,           // fixed boost in force
  output logic [7:0] fixed_boost_field_o,   // four 2-bit boosts
  input wire logic [6:0] group1_count_msb_i,   // group 1 high bits
  input wire logic group1_override_en_i,    // group 1 override
  output logic group0_manual_rate_enable_o, // group 0 override
  output logic [14:0] group0_manual_count_o, // group 0 count
  output logic group1_manual_rate_enable_o, // group 1 override
  output logic [14:0] group1_manual_count_o // group 1 count
);
  localparam int LP_W = $clog2(LP_DELAY_CYCLES + 1);
  localparam logic [LP_W-1:0] LP_LAST = LP_W'(LP_DELAY_CYCLES - 1);

  // stored registers
  logic [7:0] lock_and_dfe_limit_ctrl;
  logic [7:0] freq_tolerance_and_tap1_limit;
  logic [7:0] reference_and_search_range_ctrl;
  logic [7:0] eye_rate_and_start_index;
  logic [7:0] fixed_boost_settings;
  logic [7:0] freq_error_readback_a;
  logic [7:0] freq_error_readback_b;
  logic [7:0] reserved_area_a;
  logic [7:0] eye_lock_monitor_ctrl;
  logic [7:0] reserved_area_b;
  logic [7:0] group0_rate_count_low;
  logic [7:0] group0_rate_count_high;
  logic [7:0] group1_rate_count_low;
  logic [LP_W-1:0] lp_count;
  logic [1:0] ref_mode;
  logic [1:0] range_sel;
  logic [1:0] tol_code;
  logic [9:0] tol_scaled;
  logic [7:0] read_value;
  logic [15:0] capture_value;

  // write decode helper
  function automatic logic hit(input logic [8:0] req,
                               input logic [7:0] ofs);
    hit = (req == {1'b1, ofs});
  endfunction

  // magnitude limiter shared by both tap paths
  function automatic logic [4:0] clamp5(input logic [4:0] req,
                                        input logic [4:0] lim);
    clamp5 = (req > lim) ? lim : req;
  endfunction

  // scaled tolerance by code
  function automatic logic [9:0] scale_tol(input logic [1:0] code,
                                           input logic [7:0] tol);
    logic [9:0] base;
    logic [9:0] frac;
    base = {2'b00, tol};
    frac = {7'h00, tol[3:1]};
    case (code)
      2'b00: scale_tol = base;
      2'b01: scale_tol = base + frac;
      2'b10: scale_tol = base << 1;
      2'b11: scale_tol = (base << 1) + frac;
      default: scale_tol = base;
    endcase
  endfunction

  // named decodes
  wire [8:0] wq = {reg_wr_i, reg_addr_i};
  wire wr_lock_dfe = hit(wq, `OFS_LOCK_DFE);
  wire wr_tol_tap1 = hit(wq, `OFS_TOL_TAP1);
  wire wr_ref_range = hit(wq, `OFS_REF_RANGE);
  wire wr_eye_start = hit(wq, `OFS_EYE_START);
  wire wr_fixed = hit(wq, `OFS_FIXED_BOOST);
  wire wr_rsvd_a = hit(wq, `OFS_RSVD_A);
  wire wr_eye_watch = hit(wq, `OFS_EYE_WATCH);
  wire wr_rsvd_b = hit(wq, `OFS_RSVD_B);
  wire wr_g0_low = hit(wq, `OFS_G0_LOW);
  wire wr_g0_high = hit(wq, `OFS_G0_HIGH);
  wire wr_g1_low = hit(wq, `OFS_G1_LOW);

  // get request: the live counter is taken on the cycle after the write
  wire get_pending = freq_tolerance_and_tap1_limit[`BIT_GET_ERR];
  wire readback_load = get_pending || freq_count_valid_i;
  wire lp_disable = lock_and_dfe_limit_ctrl[`BIT_LP_DISABLE];
  wire range_override = reference_and_search_range_ctrl[`BIT_RANGE_OV];
  wire irq_enable = reference_and_search_range_ctrl[`BIT_IRQ_EN];
  wire eye_watch = eye_lock_monitor_ctrl[`BIT_EYE_WATCH];

  assign capture_value = freq_count_i;
  assign ref_mode = reference_and_search_range_ctrl[5:4];
  assign range_sel = reference_and_search_range_ctrl[1:0];
  assign tol_code = freq_tolerance_and_tap1_limit[7:6];
  assign tol_scaled = scale_tol(tol_code, tol_value_i);

  // eye opening joins the lock criteria only while watched
  lock_check_if lk ();
  assign lk.check_stb = lock_check_i;
  assign lk.criteria_ok = freq_ok_i && (!eye_watch || eye_ok_i);
  assign lk.retry_limit = lock_and_dfe_limit_ctrl[5:4];
  assign cdr_locked_o = lk.locked;

  lock_monitor u_lock_monitor (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .lk(lk)
  );

  // read selection; state registers 0x37, 0x38 and gaps return zero
  always_comb begin
    case (reg_addr_i)
      `OFS_LOCK_DFE: read_value = lock_and_dfe_limit_ctrl;
      `OFS_TOL_TAP1: read_value = freq_tolerance_and_tap1_limit;
      `OFS_REF_RANGE: read_value = reference_and_search_range_ctrl;
      `OFS_EQ_STATE: read_value = 8'h00;
      `OFS_FEQ_STATE: read_value = 8'h00;
      `OFS_EYE_START: read_value = eye_rate_and_start_index;
      `OFS_FIXED_BOOST: read_value = fixed_boost_settings;
      `OFS_ERR_A: read_value = freq_error_readback_a;
      `OFS_ERR_B: read_value = freq_error_readback_b;
      `OFS_RSVD_A: read_value = reserved_area_a;
      `OFS_EYE_WATCH: read_value = eye_lock_monitor_ctrl;
      `OFS_RSVD_B: read_value = reserved_area_b;
      `OFS_G0_LOW: read_value = group0_rate_count_low;
      `OFS_G0_HIGH: read_value = group0_rate_count_high;
      `OFS_G1_LOW: read_value = group1_rate_count_low;
      default: read_value = 8'h00;
    endcase
  end

  // read data register
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= read_value;
    end
  end

  // offset 0x34: ready flag is hardware-set and wins over a clear
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      lock_and_dfe_limit_ctrl <= `RST_LOCK_DFE;
    end else begin
      if (wr_lock_dfe) begin
        lock_and_dfe_limit_ctrl <= reg_wdata_i;
      end
      if (readback_load) begin
        lock_and_dfe_limit_ctrl[`BIT_ERR_READY] <= 1'b1;
      end
    end
  end

  // offset 0x35: get bit clears once the capture is done
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      freq_tolerance_and_tap1_limit <= `RST_TOL_TAP1;
    end else if (wr_tol_tap1) begin
      // a fresh write of one re-arms even during a capture
      freq_tolerance_and_tap1_limit <= reg_wdata_i;
    end else if (get_pending) begin
      freq_tolerance_and_tap1_limit[`BIT_GET_ERR] <= 1'b0;
    end
  end

  // frequency error readback, continuous or on request
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      freq_error_readback_a <= 8'h00;
      freq_error_readback_b <= 8'h00;
    end else if (readback_load) begin
      freq_error_readback_a <= capture_value[7:0];
      freq_error_readback_b <= capture_value[15:8];
    end
  end

  // plain control registers
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      reference_and_search_range_ctrl <= `RST_REF_RANGE;
      eye_rate_and_start_index <= `RST_EYE_START;
      fixed_boost_settings <= `RST_FIXED_BOOST;
      reserved_area_a <= `RST_RSVD;
      eye_lock_monitor_ctrl <= `RST_EYE_WATCH;
      reserved_area_b <= `RST_RSVD;
    end else begin
      if (wr_ref_range) begin
        reference_and_search_range_ctrl <= reg_wdata_i;
      end
      if (wr_eye_start) begin
        eye_rate_and_start_index <= reg_wdata_i;
      end
      if (wr_fixed) begin
        fixed_boost_settings <= reg_wdata_i;
      end
      if (wr_rsvd_a) begin
        reserved_area_a <= reg_wdata_i;
      end
      if (wr_eye_watch) begin
        eye_lock_monitor_ctrl <= reg_wdata_i;
      end
      if (wr_rsvd_b) begin
        reserved_area_b <= reg_wdata_i;
      end
    end
  end

  // manual data-rate group counts
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      group0_rate_count_low <= `RST_GROUP;
      group0_rate_count_high <= `RST_GROUP;
      group1_rate_count_low <= `RST_GROUP;
    end else begin
      if (wr_g0_low) begin
        group0_rate_count_low <= reg_wdata_i;
      end
      if (wr_g0_high) begin
        group0_rate_count_high <= reg_wdata_i;
      end
      if (wr_g1_low) begin
        group1_rate_count_low <= reg_wdata_i;
      end
    end
  end

  // low-power timer restarts when detect returns
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      lp_count <= '0;
      power_down_o <= 1'b0;
    end else if (signal_detect_i || lp_disable) begin
      lp_count <= '0;
      power_down_o <= 1'b0;
    end else if (lp_count == LP_LAST) begin
      power_down_o <= 1'b1;
    end else begin
      lp_count <= lp_count + 1'b1;
    end
  end

  // registered field outputs
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      later_step_o <= 4'h0;
      tap1_weight_o <= 5'h00;
      scaled_tol_o <= 10'h000;
      tol_active_o <= 1'b0;
      eye_irq_o <= 1'b0;
    end else begin
      // one magnitude limit serves both polarities
      later_step_o <= 4'(clamp5({1'b0, later_step_req_i},
        {1'b0, lock_and_dfe_limit_ctrl[3:0]}));
      tap1_weight_o <= clamp5(tap1_weight_req_i,
        freq_tolerance_and_tap1_limit[4:0]);
      scaled_tol_o <= tol_enable_i ? tol_scaled : 10'h000;
      tol_active_o <= tol_enable_i;
      eye_irq_o <= eye_event_i && irq_enable;
    end
  end

  // reference mode and cap-dac search decode
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      ref_clk_enable_o <= 1'b0;
      fast_lock_o <= 1'b0;
      full_search_o <= 1'b0;
      search_stop_o <= '0;
    end else begin
      ref_clk_enable_o <= ref_mode[1];
      fast_lock_o <= (ref_mode == 2'b11);
      full_search_o <= (ref_mode == 2'b11) || (ref_mode == 2'b00);
      // stop sits one to four steps below start under override
      search_stop_o <= range_override ?
        CAP_W'(search_start_i - CAP_W'({1'b0, range_sel} + 3'h1))
        : search_stop_def_i;
    end
  end

  // eye rate, start index, boost and group outputs
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      eye_rate_shift_o <= 2'h0;
      eq_start_index_o <= 5'h00;
      use_fixed_boost_o <= 1'b0;
      fixed_boost_field_o <= 8'h00;
      group0_manual_rate_enable_o <= 1'b0;
      group0_manual_count_o <= 15'h0000;
      group1_manual_rate_enable_o <= 1'b0;
      group1_manual_count_o <= 15'h0000;
    end else begin
      // without override the monitor runs at full rate
      eye_rate_shift_o <= eye_scan_override_i ?
        ~eye_rate_and_start_index[6:5] : 2'h0;
      eq_start_index_o <= eye_rate_and_start_index[4:0];
      // divide by 4 and slower counts as code two and above
      use_fixed_boost_o <= (divider_sel_i >= 3'h2) &&
        !adapt_low_rate_i;
      fixed_boost_field_o <= fixed_boost_settings;
      group0_manual_rate_enable_o <=
        group0_rate_count_high[`BIT_GROUP_OV];
      group0_manual_count_o <= {group0_rate_count_high[6:0],
        group0_rate_count_low};
      group1_manual_rate_enable_o <= group1_override_en_i;
      group1_manual_count_o <= {group1_count_msb_i,
        group1_rate_count_low};
    end
  end

endmodule // retimer_channel_lock_adapt_regs

//--- hw/retimer_lock_map.svh
`ifndef RETIMER_LOCK_MAP_SVH
`define RETIMER_LOCK_MAP_SVH

// register offsets
`define OFS_LOCK_DFE 8'h34
`define OFS_TOL_TAP1 8'h35
`define OFS_REF_RANGE 8'h36
`define OFS_EQ_STATE 8'h37
`define OFS_FEQ_STATE 8'h38
`define OFS_EYE_START 8'h39
`define OFS_FIXED_BOOST 8'h3a
`define OFS_ERR_A 8'h3b
`define OFS_ERR_B 8'h3c
`define OFS_RSVD_A 8'h3d
`define OFS_EYE_WATCH 8'h3e
`define OFS_RSVD_B 8'h3f
`define OFS_G0_LOW 8'h60
`define OFS_G0_HIGH 8'h61
`define OFS_G1_LOW 8'h62

// reset values
`define RST_LOCK_DFE 8'h3f
`define RST_TOL_TAP1 8'h1f
`define RST_REF_RANGE 8'h31
`define RST_EYE_START 8'h00
`define RST_FIXED_BOOST 8'ha5
`define RST_RSVD 8'h00
`define RST_EYE_WATCH 8'h80
`define RST_GROUP 8'h00

// field positions
`define BIT_ERR_READY 7
`define BIT_LP_DISABLE 6
`define BIT_GET_ERR 5
`define BIT_IRQ_EN 6
`define BIT_RANGE_OV 2
`define BIT_EYE_WATCH 7
`define BIT_GROUP_OV 7

// timing
`define LP_DELAY_MS 100
`define CLK_KHZ 50000

`endif

//--- hw/retimer_lock_pkg.sv
package retimer_lock_pkg;
  // lock qualification states
  typedef enum logic [1:0] {
    LK_SEARCH,
    LK_LOCKED,
    LK_RETRY
  } lock_state_t;
endpackage

//--- hw/lock_check_if.sv
`timescale 1ns/1ns
// carries lock-check traffic between the bank and the lock monitor
interface lock_check_if;
  logic check_stb;
  logic criteria_ok;
  logic [1:0] retry_limit;
  logic locked;
  modport ctrl(output check_stb, criteria_ok, retry_limit,
               input locked);
  modport mon(input check_stb, criteria_ok, retry_limit,
              output locked);
endinterface

//--- hw/lock_monitor.sv
`timescale 1ns/1ns
module lock_monitor (
  input wire logic clock_i,  // register clock
  input wire logic rst_n_i,  // sync reset, active low
  lock_check_if.mon lk       // check strobes in, lock state out
);
  retimer_lock_pkg::lock_state_t state;
  retimer_lock_pkg::lock_state_t next_state;
  logic [2:0] next_fail;
  logic [2:0] fail_cnt;
  logic [2:0] checks_allowed;

  // retry field plus one failed checks unlock
  assign checks_allowed = {1'b0, lk.retry_limit} + 3'h1;
  // indication stays high while retrying
  assign lk.locked = (state != retimer_lock_pkg::LK_SEARCH);

  // next state and failure count
  always_comb begin
    next_state = state;
    next_fail = fail_cnt;
    case (state)
      retimer_lock_pkg::LK_SEARCH: begin
        if (lk.check_stb && lk.criteria_ok) begin
          next_state = retimer_lock_pkg::LK_LOCKED;
          next_fail = 3'h0;
        end
      end
      retimer_lock_pkg::LK_LOCKED: begin
        if (lk.check_stb && !lk.criteria_ok) begin
          next_fail = 3'h1;
          if (checks_allowed == 3'h1) begin
            next_state = retimer_lock_pkg::LK_SEARCH;
            next_fail = 3'h0;
          end else begin
            next_state = retimer_lock_pkg::LK_RETRY;
          end
        end
      end
      retimer_lock_pkg::LK_RETRY: begin
        if (lk.check_stb && lk.criteria_ok) begin
          next_state = retimer_lock_pkg::LK_LOCKED;
          next_fail = 3'h0;
        end else if (lk.check_stb) begin
          next_fail = fail_cnt + 3'h1;
          if (next_fail >= checks_allowed) begin
            next_state = retimer_lock_pkg::LK_SEARCH;
            next_fail = 3'h0;
          end
        end
      end
      default: begin
        next_state = retimer_lock_pkg::LK_SEARCH;
        next_fail = 3'h0;
      end
    endcase
  end

  // state registers
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      state <= retimer_lock_pkg::LK_SEARCH;
      fail_cnt <= 3'h0;
    end else begin
      state <= next_state;
      fail_cnt <= next_fail;
    end
  end
endmodule // lock_monitor

//--- test/retimer_channel_lock_adapt_regs_monitor.sv
`timescale 1ns/1ns
module retimer_channel_lock_adapt_regs_monitor #(
  parameter int CAP_W = 5
) (
  input wire logic clock_i,                 // register clock
  input wire logic rst_n_i,                 // sync reset, active low
  input wire logic lock_check_i,            // lock check strobe
  input wire logic freq_ok_i,               // ppm criterion
  input wire logic eye_ok_i,                // eye criterion
  input wire logic cdr_locked_o,            // lock indication
  input wire logic [3:0] later_step_req_i,  // taps 2-5 request
  input wire logic [3:0] later_step_o,      // taps 2-5 limited
  input wire logic [4:0] tap1_weight_req_i, // tap 1 request
  input wire logic [4:0] tap1_weight_o,     // tap 1 limited
  input wire logic tol_enable_i,            // tolerance enable
  input wire logic [9:0] scaled_tol_o,      // scaled tolerance
  input wire logic tol_active_o,            // tolerance in use
  input wire logic eye_event_i,             // eye event
  input wire logic eye_irq_o,               // eye interrupt
  input wire logic ref_clk_enable_o,        // reference clock on
  input wire logic fast_lock_o,             // fast lock
  input wire logic full_search_o,           // full search
  input wire logic [CAP_W-1:0] search_start_i,    // search start
  input wire logic [CAP_W-1:0] search_stop_def_i, // default stop
  input wire logic [CAP_W-1:0] search_stop_o,     // stop used
  input wire logic [2:0] divider_sel_i,     // divider code
  input wire logic adapt_low_rate_i,        // low-rate adapt
  input wire logic use_fixed_boost_o,       // fixed boost
  input wire logic signal_detect_i,         // signal present
  input wire logic power_down_o             // shutdown
);
  logic live;
  // skip the first edge after reset
  always_ff @(posedge clock_i) begin
    live <= rst_n_i;
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  sequence pass_check;
    lock_check_i && freq_ok_i && eye_ok_i;
  endsequence
  chk_lock_hold: assert property (
    (cdr_locked_o ##0 pass_check) |=> cdr_locked_o)
    else $error("lock lost on pass");
  chk_unlock_cause: assert property (
    live && $fell(cdr_locked_o) |->
    $past(lock_check_i) && !$past(freq_ok_i && eye_ok_i))
    else $error("unlock without fail");
  chk_lock_rise: assert property (
    live && $rose(cdr_locked_o) |-> $past(lock_check_i && freq_ok_i))
    else $error("lock without pass");
  chk_step_limit: assert property (
    live |-> later_step_o <= $past(later_step_req_i))
    else $error("step over request");
  chk_tap1_limit: assert property (
    live |-> tap1_weight_o <= $past(tap1_weight_req_i))
    else $error("tap1 over request");
  chk_tol_gate: assert property (
    live && !$past(tol_enable_i) |-> scaled_tol_o == '0 && !tol_active_o)
    else $error("tolerance ungated");
  chk_irq_cause: assert property (
    live && eye_irq_o |-> $past(eye_event_i))
    else $error("irq without event");
  chk_mode_decode: assert property (
    fast_lock_o |-> ref_clk_enable_o && full_search_o)
    else $error("fast lock decode");
  chk_stop_range: assert property (
    live |-> search_stop_o == $past(search_stop_def_i) ||
    CAP_W'($past(search_start_i) - search_stop_o) inside {[1:4]})
    else $error("search stop out of range");
  chk_boost_gate: assert property (
    live && use_fixed_boost_o |->
    $past(divider_sel_i) >= 3'h2 && !$past(adapt_low_rate_i))
    else $error("fixed boost misuse");
  chk_power_cause: assert property (
    live && power_down_o |-> !$past(signal_detect_i))
    else $error("power down with signal");
endmodule // retimer_channel_lock_adapt_regs_monitor

//--- test/config_host_model.sv
`timescale 1ns/1ns
module config_host_model (
  input wire logic clock_i,       // register clock
  input wire logic [7:0] rdata_i, // read data
  output logic wr_o,              // write strobe
  output logic rd_o,              // read strobe
  output logic [7:0] addr_o,      // offset
  output logic [7:0] data_o       // write data
);
  initial {wr_o, rd_o, addr_o, data_o} = 18'h0;
  // lines flip after each access to expose stale use
  task automatic write(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock_i);
    #1;
    wr_o = 1'b1;
    addr_o = a;
    data_o = v;
    @(posedge clock_i);
    #1;
    wr_o = 1'b0;
    addr_o = ~a;
    data_o = ~v;
  endtask
  task automatic read(input logic [7:0] a, output logic [7:0] v);
    @(posedge clock_i);
    #1;
    rd_o = 1'b1;
    addr_o = a;
    @(posedge clock_i);
    #1;
    rd_o = 1'b0;
    addr_o = ~a;
    v = rdata_i;
  endtask
endmodule // config_host_model

//--- test/retimer_channel_lock_adapt_regs_bench.sv
`timescale 1ns/1ns
module retimer_channel_lock_adapt_regs_bench;
  localparam int LP = 20;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic reg_wr_i, reg_rd_i, freq_count_valid_i, signal_detect_i;
  logic lock_check_i, freq_ok_i, eye_ok_i, tol_enable_i, eye_event_i;
  logic eye_scan_override_i, adapt_low_rate_i, group1_override_en_i;
  logic power_down_o, cdr_locked_o, tol_active_o, eye_irq_o;
  logic ref_clk_enable_o, fast_lock_o, full_search_o, use_fixed_boost_o;
  logic group0_manual_rate_enable_o, group1_manual_rate_enable_o;
  logic [1:0] eye_rate_shift_o;
  logic [2:0] divider_sel_i;
  logic [3:0] later_step_req_i, later_step_o;
  logic [4:0] tap1_weight_req_i, tap1_weight_o, eq_start_index_o;
  logic [4:0] search_start_i, search_stop_def_i, search_stop_o;
  logic [6:0] group1_count_msb_i;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, tol_value_i;
  logic [7:0] fixed_boost_field_o, d;
  logic [9:0] scaled_tol_o;
  logic [14:0] group0_manual_count_o, group1_manual_count_o;
  logic [15:0] freq_count_i, fc;
  logic [41:0] stim;
  assign {later_step_req_i, tap1_weight_req_i, tol_value_i, tol_enable_i,
    eye_event_i, search_start_i, search_stop_def_i, eye_scan_override_i,
    divider_sel_i, adapt_low_rate_i, group1_count_msb_i,
    group1_override_en_i} = stim;
  logic [7:0] sh [15];
  logic [7:0] ofs [15] = '{8'h34, 8'h35, 8'h36, 8'h37, 8'h38, 8'h39,
    8'h3a, 8'h3b, 8'h3c, 8'h3d, 8'h3e, 8'h3f, 8'h60, 8'h61, 8'h62};
  logic [7:0] dflt [15] = '{8'h3f, 8'h1f, 8'h31, 8'h00, 8'h00, 8'h00,
    8'ha5, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00};
  int err_count = 0;
  int comparisons = 0;

  always #10 clock_i = ~clock_i;

  retimer_channel_lock_adapt_regs #(.LP_DELAY_CYCLES(LP))
    u_retimer_channel_lock_adapt_regs (.*);
  config_host_model u_config_host_model (.clock_i, .rdata_i(reg_rdata_o),
    .wr_o(reg_wr_i), .rd_o(reg_rd_i), .addr_o(reg_addr_i),
    .data_o(reg_wdata_i));

  // expected scaled tolerance
  function automatic logic [9:0] scale(input logic [1:0] c,
                                       input logic [7:0] t);
    scale = (c[1] ? {1'b0, t, 1'b0} : {2'b00, t}) +
            (c[0] ? {7'h00, t[3:1]} : 10'h000);
  endfunction

  task automatic cmp(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic rdcmp(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    u_config_host_model.read(a, v);
    cmp($sformatf("reg %h", a), e, v);
  endtask

  // one lock check, then flip the criteria
  task automatic chk(input logic f, input logic e, input logic x);
    @(posedge clock_i);
    #1;
    lock_check_i = 1'b1;
    freq_ok_i = f;
    eye_ok_i = e;
    @(posedge clock_i);
    #1;
    lock_check_i = 1'b0;
    freq_ok_i = ~f;
    eye_ok_i = ~e;
    cmp("cdr_locked_o", x, cdr_locked_o);
  endtask

  task automatic print_verdict;
    if (err_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // hang guard
  initial begin
    repeat (20000) @(posedge clock_i);
    err_count++;
    print_verdict();
  end

  initial begin
    void'($urandom(32'ha91e));
    stim = 42'h0;
    {freq_count_valid_i, lock_check_i, freq_ok_i, eye_ok_i} = 4'h0;
    signal_detect_i = 1'b1;
    freq_count_i = 16'h0000;
    repeat (6) @(posedge clock_i);
    #1;
    rst_n_i = 1'b1;
    for (int k = 0; k < 15; k++) rdcmp(ofs[k], dflt[k]);
    // random settings, two-bit codes stepped by the index
    for (int i = 0; i < 8; i++) begin
      for (int k = 0; k < 15; k++) begin
        sh[k] = (k inside {3, 4, 7, 8}) ? 8'h00 : 8'($urandom);
      end
      sh[0][7:4] = {2'b01, 2'(i)};
      sh[1][7:5] = {2'(i), 1'b0};
      sh[2][5:4] = 2'(i);
      sh[5][6:5] = 2'(i);
      for (int k = 0; k < 15; k++) begin
        u_config_host_model.write(ofs[k], k inside {3, 4, 7, 8} ?
          8'($urandom) : sh[k]);
      end
      stim = 42'({$urandom, $urandom});
      repeat (2) @(posedge clock_i);
      #1;
      cmp("later_step_o", later_step_req_i < sh[0][3:0] ?
          later_step_req_i : sh[0][3:0], later_step_o);
      cmp("tap1_weight_o", tap1_weight_req_i < sh[1][4:0] ?
          tap1_weight_req_i : sh[1][4:0], tap1_weight_o);
      cmp("scaled_tol_o", tol_enable_i ? scale(sh[1][7:6], tol_value_i) :
          10'h000, scaled_tol_o);
      cmp("tol_active_o", tol_enable_i, tol_active_o);
      cmp("eye_irq_o", eye_event_i & sh[2][6], eye_irq_o);
      cmp("ref_mode", {sh[2][5], sh[2][5:4] == 2'b11, sh[2][5] == sh[2][4]},
          {ref_clk_enable_o, fast_lock_o, full_search_o});
      cmp("search_stop_o", sh[2][2] ? 5'(search_start_i - sh[2][1:0] - 1)
          : search_stop_def_i, search_stop_o);
      cmp("eye_rate_shift_o", eye_scan_override_i ? 2'(3 - sh[5][6:5]) :
          2'h0, eye_rate_shift_o);
      cmp("eq_start_index_o", sh[5][4:0], eq_start_index_o);
      cmp("boost", {divider_sel_i >= 3'h2 && !adapt_low_rate_i, sh[6]},
          {use_fixed_boost_o, fixed_boost_field_o});
      cmp("group0", {sh[13], sh[12]}, {group0_manual_rate_enable_o,
          group0_manual_count_o});
      cmp("group1", {group1_override_en_i, group1_count_msb_i, sh[14]},
          {group1_manual_rate_enable_o, group1_manual_count_o});
    end
    for (int k = 0; k < 15; k++) rdcmp(ofs[k], sh[k]);
    u_config_host_model.write(8'h70, 8'h5a);
    rdcmp(8'h70, 8'h00);
    // valid pulse load, then get-bit load
    fc = 16'($urandom);
    freq_count_i = fc;
    freq_count_valid_i = 1'b1;
    @(posedge clock_i);
    #1;
    freq_count_valid_i = 1'b0;
    freq_count_i = ~fc;
    u_config_host_model.write(8'h3b, 8'h5a);
    rdcmp(8'h3b, fc[7:0]);
    rdcmp(8'h3c, fc[15:8]);
    rdcmp(8'h34, {1'b1, sh[0][6:0]});
    u_config_host_model.write(8'h34, sh[0]);
    u_config_host_model.write(8'h35, sh[1] | 8'h20);
    rdcmp(8'h3b, ~fc[7:0]);
    rdcmp(8'h3c, ~fc[15:8]);
    rdcmp(8'h35, sh[1]);
    rdcmp(8'h34, {1'b1, sh[0][6:0]});
    // retry 0 to 3, a pass mid-retry restarts
    u_config_host_model.write(8'h3e, 8'h80);
    for (int r = 0; r < 4; r++) begin
      u_config_host_model.write(8'h34, {2'b01, 2'(r), 4'hf});
      chk(1'b1, 1'b1, 1'b1);
      repeat (r) chk(1'b0, 1'b1, 1'b1);
      chk(1'b1, 1'b1, 1'b1);
      repeat (r) chk(1'b0, 1'b1, 1'b1);
      chk(1'b1, 1'b0, 1'b0);
    end
    u_config_host_model.write(8'h3e, 8'h00);
    chk(1'b1, 1'b0, 1'b1);
    // low power after the short delay
    u_config_host_model.write(8'h34, 8'h3f);
    signal_detect_i = 1'b0;
    repeat (LP - 1) @(posedge clock_i);
    #1;
    cmp("power_down_o", 0, power_down_o);
    @(posedge clock_i);
    #1;
    cmp("power_down_o", 1, power_down_o);
    signal_detect_i = 1'b1;
    @(posedge clock_i);
    #1;
    cmp("power_down_o", 0, power_down_o);
    // second reset in mid-run
    rst_n_i = 1'b0;
    repeat (2) @(posedge clock_i);
    #1;
    rst_n_i = 1'b1;
    rdcmp(8'h36, 8'h31);
    print_verdict();
  end
endmodule // retimer_channel_lock_adapt_regs_bench

bind retimer_channel_lock_adapt_regs retimer_channel_lock_adapt_regs_monitor
  #(.CAP_W(CAP_W)) u_monitor (.*);
